/* ddcpc_pkg.sv */
// constants and register map of the digital down-conversion path configuration
// assumes a host on a byte-wide register port and a sample stream on one clock
// Operation
// - source select 00 routes A to down-converter A, 01 to both.
// - digital-path bit 0 bypasses feature block, 1 passes through it only while the decimator-enable bit is also set.
// - one decimator-enable bit turns decimation of both channels on or off.
// - source select acts only while the multiplexer-apply bit is set.
// - three-bit field: 000 none, 001..101 decimate by 2 to 32.
// - real-output bit gives low-pass only, no mixing; clear gives complex mixing. No low-pass filter is built: real output passes the samples unfiltered.
// - phase-invert bit inverts the oscillator phase.
// - channel A gain code 00 none, 01 3 dB, 10 6 dB.
// - channel B gain uses the same encoding as channel A.
// - toggling restart A resets phase A and loads new frequency; never self-clears.
// - toggling restart B resets phase B and loads new frequency; never self-clears.
// - quarter-rate bit A mixes down-converter A by a quarter sample rate.
// - quarter-rate bit B mixes down-converter B by a quarter sample rate.
// - each oscillator frequency word is 32 bits, f times 2^32 over rate.
// - real decimation forces oscillator frequency words to zero.
package ddcpc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIGITAL_PATH_CONTROL = 8'h24;
  localparam logic [7:0] OFS_DECIMATION_CONFIG = 8'h25;
  localparam logic [7:0] OFS_MIXER_CONFIG = 8'h26;
  localparam logic [7:0] OFS_FREQ_A0 = 8'h2a;
  localparam logic [7:0] OFS_FREQ_B0 = 8'h31;
  localparam logic [7:0] OFS_PATH_STATUS = 8'h38;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SRC_SEL_LO = 3;
  localparam int BIT_DIG_PATH = 2;
  localparam int BIT_DEC_EN = 1;
  localparam int BIT_MUX_APPLY = 7;
  localparam int BIT_DEC_LO = 4;
  localparam int BIT_REAL_OUT = 3;
  localparam int BIT_PHASE_INV = 0;
  localparam int BIT_GAIN_A_LO = 6;
  localparam int BIT_RESTART_A = 5;
  localparam int BIT_QUARTER_A = 4;
  localparam int BIT_GAIN_B_LO = 2;
  localparam int BIT_RESTART_B = 1;
  localparam int BIT_QUARTER_B = 0;

  // writable bits per register; the rest store nothing
  localparam logic [7:0] MASK_DIGITAL_PATH_CONTROL = 8'h1e;
  localparam logic [7:0] MASK_DECIMATION_CONFIG = 8'hf9;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIGITAL_PATH_CONTROL = 8'h00;
  localparam logic [7:0] RST_DECIMATION_CONFIG = 8'h00;
  localparam logic [7:0] RST_MIXER_CONFIG = 8'h00;
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [1:0] SRC_A_TO_A = 2'h0;
  localparam logic [1:0] SRC_A_TO_BOTH = 2'h1;
  localparam logic [2:0] DEC_MAX_CODE = 3'h5;
  localparam logic [1:0] GAIN_NONE = 2'h0;
  localparam logic [1:0] GAIN_3DB = 2'h1;
  localparam logic [1:0] GAIN_6DB = 2'h2;
  localparam logic [31:0] QUARTER_RATE_STEP = 32'h4000_0000;
  localparam int FIFO_DEPTH = 8;

endpackage : ddcpc_pkg

/* ddcpc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ddcpc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH):0] count_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign count_o = count_reg;

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  // depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      if (push && !pop) count_reg <= count_reg + (AW+1)'(1);
      else if (pop && !push) count_reg <= count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data_i;
  end

endmodule // ddcpc_fifo

/* ddcpc_top.sv */
// configuration registers and sample path of the down-conversion feature block
// assumes samples synchronous to clk_i and a host on the byte register port
`timescale 1ns/10ps
module ddcpc_top
  import ddcpc_pkg::*;
#(
  parameter int SW = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // converter samples
  input wire logic signed [SW-1:0] smp_a_i,
  input wire logic signed [SW-1:0] smp_b_i,
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  // output words {a_i, a_q, b_i, b_q}
  output logic [4*SW-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic signed [SW-1:0] sat(input logic signed [SW+1:0] v);
    logic signed [SW+1:0] hi;
    logic signed [SW+1:0] lo;
    hi = (SW+2)'((2**(SW-1))-1);
    lo = -hi - (SW+2)'(1);
    if (v > hi) sat = SW'(hi);
    else if (v < lo) sat = SW'(lo);
    else sat = SW'(v);
  endfunction

  // 3 dB approximated as 1.375 to stay multiplier-free
  function automatic logic signed [SW-1:0] gain(input logic signed [SW-1:0] x, input logic [1:0] code);
    logic signed [SW+1:0] w;
    w = (SW+2)'(x);
    unique case (code)
      GAIN_3DB: gain = sat(w + (w >>> 1) - (w >>> 3));
      GAIN_6DB: gain = sat(w <<< 1);
      default: gain = x;
    endcase
  endfunction

  // coarse quadrant mixer; returns {i, q}
  function automatic logic [2*SW-1:0] mix(input logic signed [SW-1:0] x, input logic [1:0] quad,
                                          input logic inv);
    logic signed [SW-1:0] nx;
    logic signed [SW-1:0] i;
    logic signed [SW-1:0] q;
    nx = sat(-(SW+2)'(x));
    i = '0;
    q = '0;
    unique case (quad)
      2'h0: i = x;
      2'h1: q = nx;
      2'h2: i = nx;
      2'h3: q = x;
    endcase
    if (inv) q = sat(-(SW+2)'(q));
    mix = {i, q};
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] path_ctrl_reg;
  logic [7:0] dec_cfg_reg;
  logic [7:0] mix_cfg_reg;
  logic [31:0] freq_a_reg;
  logic [31:0] freq_b_reg;
  logic [7:0] rdata_reg;

  wire logic wr_path = wr_i && (addr_i == OFS_DIGITAL_PATH_CONTROL);
  wire logic wr_dec = wr_i && (addr_i == OFS_DECIMATION_CONFIG);
  wire logic wr_mix = wr_i && (addr_i == OFS_MIXER_CONFIG);
  wire logic [7:0] freq_a_idx = addr_i - OFS_FREQ_A0;
  wire logic [7:0] freq_b_idx = addr_i - OFS_FREQ_B0;
  wire logic wr_fa = wr_i && (freq_a_idx < 8'h04);
  wire logic wr_fb = wr_i && (freq_b_idx < 8'h04);

  wire logic [1:0] src_sel = path_ctrl_reg[BIT_SRC_SEL_LO +: 2];
  wire logic dig_path = path_ctrl_reg[BIT_DIG_PATH];
  wire logic dec_en = path_ctrl_reg[BIT_DEC_EN];
  wire logic mux_apply = dec_cfg_reg[BIT_MUX_APPLY];
  wire logic [2:0] dec_code = dec_cfg_reg[BIT_DEC_LO +: 3];
  wire logic real_out = dec_cfg_reg[BIT_REAL_OUT];
  wire logic phase_inv = dec_cfg_reg[BIT_PHASE_INV];
  wire logic [1:0] gain_a = mix_cfg_reg[BIT_GAIN_A_LO +: 2];
  wire logic [1:0] gain_b = mix_cfg_reg[BIT_GAIN_B_LO +: 2];
  wire logic quarter_a = mix_cfg_reg[BIT_QUARTER_A];
  wire logic quarter_b = mix_cfg_reg[BIT_QUARTER_B];
  wire logic real_next = wr_dec ? wdata_i[BIT_REAL_OUT] : real_out;

  // restart fires on any change of the stored bit, so both edges count
  wire logic restart_a = wr_mix && (wdata_i[BIT_RESTART_A] != mix_cfg_reg[BIT_RESTART_A]);
  wire logic restart_b = wr_mix && (wdata_i[BIT_RESTART_B] != mix_cfg_reg[BIT_RESTART_B]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      path_ctrl_reg <= RST_DIGITAL_PATH_CONTROL;
      dec_cfg_reg <= RST_DECIMATION_CONFIG;
      mix_cfg_reg <= RST_MIXER_CONFIG;
    end else begin
      if (wr_path) path_ctrl_reg <= wdata_i & MASK_DIGITAL_PATH_CONTROL;
      if (wr_dec) dec_cfg_reg <= wdata_i & MASK_DECIMATION_CONFIG;
      if (wr_mix) mix_cfg_reg <= wdata_i;
    end
  end

  // frequency words, zero in real mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_a_reg <= RST_FREQ;
      freq_b_reg <= RST_FREQ;
    end else if (real_next) begin
      freq_a_reg <= '0;
      freq_b_reg <= '0;
    end else begin
      if (wr_fa) freq_a_reg[freq_a_idx[1:0]*8 +: 8] <= wdata_i;
      if (wr_fb) freq_b_reg[freq_b_idx[1:0]*8 +: 8] <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------
  logic [31:0] step_a_reg;
  logic [31:0] step_b_reg;
  logic [31:0] phase_a_reg;
  logic [31:0] phase_b_reg;
  logic [4:0] dec_cnt_reg;
  wire logic take = smp_valid_i && smp_ready_o;

  wire logic [31:0] incr_a = real_out ? '0 : (quarter_a ? QUARTER_RATE_STEP : step_a_reg);
  wire logic [31:0] incr_b = real_out ? '0 : (quarter_b ? QUARTER_RATE_STEP : step_b_reg);

  // a new frequency only takes hold at restart, so retuning is glitch-free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_a_reg <= RST_FREQ;
      step_b_reg <= RST_FREQ;
      phase_a_reg <= '0;
      phase_b_reg <= '0;
    end else begin
      if (restart_a) begin
        step_a_reg <= freq_a_reg;
        phase_a_reg <= '0;
      end else if (take) phase_a_reg <= phase_a_reg + incr_a;
      if (restart_b) begin
        step_b_reg <= freq_b_reg;
        phase_b_reg <= '0;
      end else if (take) phase_b_reg <= phase_b_reg + incr_b;
    end
  end

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  // source multiplexer
  wire logic both_from_a = mux_apply && (src_sel == SRC_A_TO_BOTH);
  wire logic signed [SW-1:0] src_a = smp_a_i;
  wire logic signed [SW-1:0] src_b = both_from_a ? smp_a_i : smp_b_i;

  // ratio 2^code; unused codes fall back to no decimation
  wire logic [4:0] dec_last = (dec_code <= DEC_MAX_CODE) ? 5'((6'h1 << dec_code) - 6'h1) : 5'h0;
  wire logic feature_dec = dig_path && dec_en;
  wire logic keep = !feature_dec || (dec_cnt_reg == 5'h0);

  wire logic [2*SW-1:0] mixed_a = mix(src_a, phase_a_reg[31:30], phase_inv);
  wire logic [2*SW-1:0] mixed_b = mix(src_b, phase_b_reg[31:30], phase_inv);
  wire logic [2*SW-1:0] iq_a = real_out ? {src_a, SW'(0)} : mixed_a;
  wire logic [2*SW-1:0] iq_b = real_out ? {src_b, SW'(0)} : mixed_b;

  wire logic [4*SW-1:0] feat_word = {gain(iq_a[2*SW-1:SW], gain_a), gain(iq_a[SW-1:0], gain_a),
                                     gain(iq_b[2*SW-1:SW], gain_b), gain(iq_b[SW-1:0], gain_b)};
  wire logic [4*SW-1:0] plain_word = {src_a, SW'(0), src_b, SW'(0)};
  // bypass skips mixing, gain and decimation; the source multiplexer still acts
  wire logic [4*SW-1:0] path_word = feature_dec ? feat_word : plain_word;

  // decimation drops samples without a filter; an external stage must band-limit
  always_ff @(posedge clk_i) begin
    if (rst_i) dec_cnt_reg <= 5'h0;
    else if (!feature_dec) dec_cnt_reg <= 5'h0;
    else if (take) dec_cnt_reg <= (dec_cnt_reg >= dec_last) ? 5'h0 : dec_cnt_reg + 5'h1;
  end

  logic [$clog2(DEPTH):0] fifo_count;
  wire logic push_valid = smp_valid_i && keep;

  ddcpc_fifo #(
    .WIDTH(4*SW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(smp_ready_o),
    .in_data_i(path_word),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o),
    .count_o(fifo_count)
  );

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  wire logic [7:0] status_word = {2'h0, real_out, feature_dec, 4'(fifo_count)};
  wire logic [7:0] read_mux =
    (addr_i == OFS_DIGITAL_PATH_CONTROL) ? path_ctrl_reg :
    (addr_i == OFS_DECIMATION_CONFIG) ? dec_cfg_reg :
    (addr_i == OFS_MIXER_CONFIG) ? mix_cfg_reg :
    (freq_a_idx < 8'h04) ? freq_a_reg[freq_a_idx[1:0]*8 +: 8] :
    (freq_b_idx < 8'h04) ? freq_b_reg[freq_b_idx[1:0]*8 +: 8] :
    (addr_i == OFS_PATH_STATUS) ? status_word : 8'h00;

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_reg <= 8'h00;
    else if (rd_i) rdata_reg <= read_mux;
    else rdata_reg <= 8'h00;
  end
  assign rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_toggle_a;
    wr_mix && (wdata_i[BIT_RESTART_A] != mix_cfg_reg[BIT_RESTART_A]);
  endsequence

  sequence s_toggle_b;
    wr_mix && (wdata_i[BIT_RESTART_B] != mix_cfg_reg[BIT_RESTART_B]);
  endsequence

  property p_restart_a;
    @(posedge clk_i) disable iff (rst_i)
      s_toggle_a |=> (phase_a_reg == 32'h0) && (step_a_reg == $past(freq_a_reg)) && (mix_cfg_reg == $past(wdata_i));
  endproperty
  a_restart_a: assert property (p_restart_a) else $error("restart a did not reset phase");

  property p_restart_b;
    @(posedge clk_i) disable iff (rst_i)
      s_toggle_b |=> (phase_b_reg == 32'h0) && (step_b_reg == $past(freq_b_reg));
  endproperty
  a_restart_b: assert property (p_restart_b) else $error("restart b did not reset phase");

  property p_real_zero;
    @(posedge clk_i) disable iff (rst_i)
      (wr_dec && wdata_i[BIT_REAL_OUT]) |=> (freq_a_reg == 32'h0) && (freq_b_reg == 32'h0) && real_out;
  endproperty
  a_real_zero: assert property (p_real_zero) else $error("frequency not cleared in real mode");

  property p_mux_both;
    @(posedge clk_i) disable iff (rst_i)
      (mux_apply && (src_sel == SRC_A_TO_BOTH)) |-> (src_b == smp_a_i);
  endproperty
  a_mux_both: assert property (p_mux_both) else $error("source a not routed to both");

  property p_mux_off;
    @(posedge clk_i) disable iff (rst_i)
      !mux_apply |-> (src_b == smp_b_i);
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("mux acted while not applied");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
      (!dig_path && take) |-> push_valid && (path_word[SW-1:0] == '0);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered the samples");

  sequence s_dec2_pair;
    (feature_dec && dec_code == 3'h1 && take && keep) ##1 (feature_dec && dec_code == 3'h1 && take)[*1];
  endsequence

  property p_dec2;
    @(posedge clk_i) disable iff (rst_i)
      s_dec2_pair |-> !keep;
  endproperty
  a_dec2: assert property (p_dec2) else $error("decimation by two kept two samples");

  property p_dec_off;
    @(posedge clk_i) disable iff (rst_i)
      (dig_path && !dec_en && smp_valid_i) |-> keep;
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("samples dropped with decimator off");

  property p_quarter;
    @(posedge clk_i) disable iff (rst_i)
      (quarter_a && !real_out && take && !restart_a) |=> (phase_a_reg == $past(phase_a_reg) + QUARTER_RATE_STEP);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter-rate step wrong");

  property p_real_nomix;
    @(posedge clk_i) disable iff (rst_i)
      (real_out && take) |=> (phase_a_reg == $past(phase_a_reg)) || $past(restart_a);
  endproperty
  a_real_nomix: assert property (p_real_nomix) else $error("oscillator ran in real mode");

  property p_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == OFS_DECIMATION_CONFIG) |=> (rdata_o == $past(dec_cfg_reg)) ##1 (rdata_o == 8'h00 || $past(rd_i));
  endproperty
  a_read: assert property (p_read) else $error("read data wrong or held");

  property p_quarter_b;
    @(posedge clk_i) disable iff (rst_i)
      (quarter_b && !real_out && take && !restart_b) |=> (phase_b_reg == $past(phase_b_reg) + QUARTER_RATE_STEP);
  endproperty
  a_quarter_b: assert property (p_quarter_b) else $error("quarter-rate step wrong on b");

  property p_real_iq;
    @(posedge clk_i) disable iff (rst_i)
      (feature_dec && real_out) |-> (feat_word[3*SW-1:2*SW] == '0) && (feat_word[SW-1:0] == '0);
  endproperty
  a_real_iq: assert property (p_real_iq) else $error("quadrature output not zero in real mode");

  property p_gain_a;
    @(posedge clk_i) disable iff (rst_i)
      (gain_a == GAIN_6DB && iq_a[2*SW-1:2*SW-2] == 2'b00) |-> (feat_word[4*SW-1:3*SW] == {iq_a[2*SW-2:SW], 1'b0});
  endproperty
  a_gain_a: assert property (p_gain_a) else $error("6 dB gain on a wrong");

  property p_bypass_word;
    @(posedge clk_i) disable iff (rst_i)
      !dig_path |-> (path_word == {smp_a_i, SW'(0), src_b, SW'(0)});
  endproperty
  a_bypass_word: assert property (p_bypass_word) else $error("bypass word not plain samples");

endmodule // ddcpc_top

/* ddcpc_host.sv */
// host model driving the byte-wide register port of the block
// assumes one bench process calls its tasks, one at a time
`timescale 1ns/10ps
module ddcpc_host
  import ddcpc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one-cycle write strobe; a gap cycle keeps strobes from colliding
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask

  // ----------------------------------------------------------------
  // configuration helpers
  // ----------------------------------------------------------------
  // reserved bits zero, decimation needs path bit
  task automatic set_path(input logic [1:0] src, input logic feat, input logic dec);
    wr_reg(OFS_DIGITAL_PATH_CONTROL, {3'h0, src, feat, dec, 1'b0});
  endtask

  task automatic set_real(input logic inv);
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_FREQ_A0 + 8'(i), 8'h00);
      wr_reg(OFS_FREQ_B0 + 8'(i), 8'h00);
    end
    wr_reg(OFS_DECIMATION_CONFIG, {4'h0, 1'b1, 2'h0, inv});
  endtask

  // frame-clock pattern set beside this block; lanes 2 two, 1 one, 0 half; res 0..3 is 14..20 bits
  function automatic logic [19:0] frame_pattern(input logic real_mode, input logic [1:0] lanes,
                                                input logic [1:0] res);
    logic [19:0] p;
    p = 20'hffc00;
    if (!real_mode && lanes != 2'h2) p = 20'hfffff;
    if (real_mode && lanes == 2'h1) p = (res == 2'h0) ? 20'hfe000 : (res == 2'h1) ? 20'hff000 : 20'hff800;
    if (real_mode && lanes == 2'h1 && res == 2'h3) p = 20'hffc00;
    return p;
  endfunction
endmodule // ddcpc_host

/* ddcpc_top_tb.sv */
// self-checking bench of the down-conversion path configuration block
// assumes package, fifo, top and host model are compiled before it
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module ddcpc_top_tb;
  import ddcpc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i, wdata_i, rdata_o, rv, wv;
  logic wr_i, rd_i, smp_ready_o, out_valid_o;
  logic [15:0] smp_a_i = 16'h0000;
  logic [15:0] smp_b_i = 16'h0000;
  logic smp_valid_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic [63:0] out_data_o, ew;
  logic [63:0] exp_q[$];
  logic [15:0] a, b;
  logic [1:0] rdy_mode = 2'h2;
  logic [7:0] msk [3] = '{MASK_DIGITAL_PATH_CONTROL, MASK_DECIMATION_CONFIG, 8'hff};
  logic [7:0] regs [6] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h31, 8'h30};
  logic [7:0] mix_seq [3] = '{8'h01, 8'h23, 8'h11};
  int n_fail = 0;
  int checks_done = 0;
  int seed = 82;
  int code;

  always #4 clk_i = ~clk_i;

  ddcpc_top #(.SW(16), .DEPTH(8)) ddcpc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .smp_a_i(smp_a_i), .smp_b_i(smp_b_i), .smp_valid_i(smp_valid_i),
    .smp_ready_o(smp_ready_o), .out_data_o(out_data_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i)
  );
  ddcpc_host ddcpc_host_inst (
    .clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o)
  );

  // ----------------------------------------------------------------
  // expectations and drivers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat(input int v);
    return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : v[15:0];
  endfunction
  function automatic logic [15:0] gn(input logic [15:0] x, input logic [1:0] g);
    int s;
    s = $signed(x);
    return (g == GAIN_3DB) ? sat(s + s / 4 + s / 8) : (g == GAIN_6DB) ? sat(2 * s) : x;
  endfunction
  // quadrant mix, optional q inversion, then gain
  function automatic logic [31:0] mx(input logic [15:0] x, input int qd, input logic inv, input logic [1:0] g);
    logic [15:0] i, q;
    i = (qd == 0) ? x : (qd == 2) ? -x : 16'h0000;
    q = (qd == 1) ? -x : (qd == 3) ? x : 16'h0000;
    if (inv) q = -q;
    return {gn(i, g), gn(q, g)};
  endfunction
  // multiples of 8 keep the 3 dB figure exact, half range avoids negating the minimum
  function automatic logic [15:0] rs();
    logic [15:0] v;
    v = $random(seed);
    return {v[15], v[15:4], 3'h0};
  endfunction

  always @(posedge clk_i) out_ready_i <= (rdy_mode == 2'h2) ? 1'($random(seed)) : rdy_mode[0];
  always @(posedge clk_i) begin
    if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      ew = (exp_q.size() > 0) ? exp_q.pop_front() : ~out_data_o;
      `CHK("out word", ew, out_data_o)
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input logic [15:0] sa, input logic [15:0] sb, input logic keep, input logic [63:0] w);
    logic acc;
    acc = 1'b0;
    smp_a_i <= sa;
    smp_b_i <= sb;
    smp_valid_i <= 1'b1;
    for (int t = 0; t < 300 && !acc; t++) begin
      @(negedge clk_i);
      acc = (smp_ready_o === 1'b1);
      @(posedge clk_i);
    end
    if (!acc) begin
      n_fail++;
      results();
    end
    if (keep) exp_q.push_back(w);
  endtask
  task automatic fin(input string nm);
    smp_valid_i <= 1'b0;
    for (int t = 0; t < 400 && (exp_q.size() != 0 || out_valid_o !== 1'b0); t++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK("missing words", 0, exp_q.size())
    `CHK("drained", 1'b0, out_valid_o)
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    ddcpc_host_inst.wr_reg(8'h30, 8'hff);
    foreach (regs[i]) begin
      ddcpc_host_inst.rd_reg(regs[i], rv);
      `CHK("reset value", 8'h00, rv)
    end
    for (int i = 0; i < 12; i++) begin
      wv = $random(seed);
      ddcpc_host_inst.wr_reg(OFS_DIGITAL_PATH_CONTROL + 8'(i % 3), wv);
      ddcpc_host_inst.rd_reg(OFS_DIGITAL_PATH_CONTROL + 8'(i % 3), rv);
      `CHK("reg rw", wv & msk[i % 3], rv)
    end
    ddcpc_host_inst.wr_reg(OFS_MIXER_CONFIG, 8'h00);
    $display("test registers done");
    // bypass, decimator off, then decimation codes 0 to 5
    for (int m = 0; m < 8; m++) begin
      code = (m < 2) ? 1 : m - 2;
      ddcpc_host_inst.wr_reg(OFS_DECIMATION_CONFIG, {1'b0, 3'(code), 4'h0});
      ddcpc_host_inst.set_path(2'h0, m > 0, m != 1);
      for (int k = 0; k < (2 << code) + 1; k++) begin
        a = rs();
        b = rs();
        send(a, b, (m < 2) || (k % (1 << code) == 0), {mx(a, 0, 1'b0, 2'h0), mx(b, 0, 1'b0, 2'h0)});
      end
      fin("decimation");
      ddcpc_host_inst.set_path(2'h0, 1'b0, 1'b0);
    end
    // post-mixer gain, saturating corners first
    ddcpc_host_inst.wr_reg(OFS_DECIMATION_CONFIG, 8'h00);
    ddcpc_host_inst.set_path(2'h0, 1'b1, 1'b1);
    for (int g = 0; g < 4; g++) begin
      ddcpc_host_inst.wr_reg(OFS_MIXER_CONFIG, {2'(g), 2'h0, 2'(g + 1), 2'h0});
      for (int k = 0; k < 6; k++) begin
        a = (k == 0) ? 16'h7ff8 : (k == 1) ? 16'h8000 : rs();
        b = rs();
        send(a, b, 1'b1, {mx(a, 0, 1'b0, 2'(g)), mx(b, 0, 1'b0, 2'(g + 1))});
      end
      fin("gain");
    end
    // frequency word used only after a restart toggle
    for (int i = 0; i < 4; i++) begin
      ddcpc_host_inst.wr_reg(OFS_FREQ_A0 + 8'(i), QUARTER_RATE_STEP[8 * i +: 8]);
    end
    ddcpc_host_inst.rd_reg(OFS_FREQ_A0 + 8'h03, rv);
    `CHK("freq byte", QUARTER_RATE_STEP[31:24], rv)
    for (int p = 0; p < 3; p++) begin
      ddcpc_host_inst.wr_reg(OFS_DECIMATION_CONFIG, {7'h00, p == 2});
      ddcpc_host_inst.wr_reg(OFS_MIXER_CONFIG, mix_seq[p]);
      for (int k = 0; k < 8; k++) begin
        a = rs();
        b = rs();
        send(a, b, 1'b1, {mx(a, (p == 0) ? 0 : k % 4, p == 2, 2'h0), mx(b, k % 4, p == 2, 2'h0)});
      end
      fin("oscillator");
    end
    // real mode zeroes and locks the frequency words
    ddcpc_host_inst.wr_reg(OFS_DECIMATION_CONFIG, 8'h08);
    ddcpc_host_inst.wr_reg(OFS_FREQ_A0, 8'h55);
    for (int i = 0; i < 2; i++) begin
      ddcpc_host_inst.rd_reg(OFS_FREQ_A0 + 8'(3 * i), rv);
      `CHK("freq forced", 8'h00, rv)
    end
    ddcpc_host_inst.set_real(1'b0);
    ddcpc_host_inst.wr_reg(OFS_MIXER_CONFIG, 8'h22);
    for (int k = 0; k < 6; k++) begin
      a = rs();
      b = rs();
      send(a, b, 1'b1, {mx(a, 0, 1'b0, 2'h0), mx(b, 0, 1'b0, 2'h0)});
    end
    fin("real");
    // source select acts only with the apply bit
    for (int m = 0; m < 3; m++) begin
      ddcpc_host_inst.wr_reg(OFS_DECIMATION_CONFIG, {m > 0, 7'h00});
      ddcpc_host_inst.set_path({1'b0, m < 2}, 1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
        a = rs();
        b = rs();
        send(a, b, 1'b1, {mx(a, 0, 1'b0, 2'h0), mx((m == 1) ? a : b, 0, 1'b0, 2'h0)});
      end
      fin("source mux");
    end
    // fill the buffer with the drain stalled, then drain it
    ddcpc_host_inst.set_path(2'h0, 1'b0, 1'b0);
    rdy_mode <= 2'h0;
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      a = rs();
      b = rs();
      send(a, b, 1'b1, {mx(a, 0, 1'b0, 2'h0), mx(b, 0, 1'b0, 2'h0)});
    end
    smp_valid_i <= 1'b0;
    @(negedge clk_i);
    `CHK("ready when full", 1'b0, smp_ready_o)
    ddcpc_host_inst.rd_reg(OFS_PATH_STATUS, rv);
    `CHK("status", 8'h08, rv)
    rdy_mode <= 2'h2;
    fin("fifo");
    results();
  end
endmodule // ddcpc_top_tb
